/* hdl/qp_consts.svh */
/*
  Constants of the quad potentiometer serial port: frame layout, identity
  byte fields, reset values and host timing counts.
  Assumes it is included by bare name, before any file that uses the macros.
*/
// How it works
// - Device changes serial output on falling clock
// - Device samples serial input on rising clock
// - Select high: output released, device goes standby
// - Select low: device enabled and active
// - Host raises select before first operation
// - Host changes pause only while clock low
// - Pause keeps partial sequence, resumes afterwards
// - Host without pause keeps pause high
// - Address pins give slave address low bits
// - Address mismatch: device stays silent
// - At most four devices share one bus
// - Four channels, own wiper and stored registers
// - Wiper register picks one of 256 taps
// - Wiper and stored registers readable and writable
// - Power-up copies stored setting zero into wiper
// - First byte: type code, zeros, address
// - Second byte: opcode, register, channel
// - Write-protect low blocks stored setting writes
`ifndef QP_CONSTS_SVH
`define QP_CONSTS_SVH

// ----------------------------------------------------------------
// Identity byte fields
// ----------------------------------------------------------------
// Device type code; the value is arbitrary
`define QP_DEV_TYPE      4'hA
`define QP_ID_TYPE_MSB   7
`define QP_ID_TYPE_LSB   4
`define QP_ID_ZERO_MSB   3
`define QP_ID_ZERO_LSB   2
`define QP_ID_ADDR_MSB   1
`define QP_ID_ADDR_LSB   0

// ----------------------------------------------------------------
// Instruction byte fields
// ----------------------------------------------------------------
`define QP_INS_OP_MSB    7
`define QP_INS_OP_LSB    4
`define QP_INS_REG_MSB   3
`define QP_INS_REG_LSB   2
`define QP_INS_CH_MSB    1
`define QP_INS_CH_LSB    0

// ----------------------------------------------------------------
// Frame bit positions (count of rising edges minus one) and frame bit counts
// ----------------------------------------------------------------
`define QP_ID_LAST       5'h07
`define QP_INS_LAST      5'h0F
`define QP_DATA_FIRST    5'h10
`define QP_DATA_LAST     5'h17
`define QP_FRAME_END     5'h18
`define QP_SHORT_BITS    5'h10
`define QP_LONG_BITS     5'h18

// ----------------------------------------------------------------
// Reset values and host timing
// ----------------------------------------------------------------
`define QP_STORED_RESET  8'h80
`define QP_SCK_HALF_DEF  4
`define QP_CS_GAP_CYC    8'h10

`endif

/* hdl/qp_pkg.sv */
/*
  Package of the quad potentiometer serial port: operation codes, host
  states and the identity byte builder shared by both ends.
  Assumes qp_consts.svh is on the include path.
*/
`include "qp_consts.svh"

package qp_pkg;

  // ----------------------------------------------------------------
  // Operation codes carried in the instruction byte
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    QP_OP_RD_WIPER  = 4'h9,
    QP_OP_WR_WIPER  = 4'hA,
    QP_OP_RD_STORED = 4'hB,
    QP_OP_WR_STORED = 4'hC,
    QP_OP_XFR       = 4'hD
  } qp_op_t;

  // ----------------------------------------------------------------
  // Host sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    QP_ST_IDLE  = 4'b0001,
    QP_ST_LEAD  = 4'b0010,
    QP_ST_SHIFT = 4'b0100,
    QP_ST_TAIL  = 4'b1000
  } qp_state_t;

  typedef logic [7:0] qp_byte_t;

  // Identity byte; two address bits limit a bus to four parts
  function automatic qp_byte_t qp_id_byte(input logic [1:0] addr);
    qp_byte_t b;
    b = {`QP_DEV_TYPE, 2'b00, addr};
    return b;
  endfunction : qp_id_byte

endpackage : qp_pkg

/* hdl/qp_link_if.sv */
/*
  Serial link between the host end and the potentiometer end.
  Assumes the data output is pulled high whenever the device releases it.
*/
interface qp_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe_n;
  logic hold_n;
  logic so_line;

  // Resolved output wire, pull-up while released
  assign so_line = so_oe_n ? 1'b1 : so;

  modport dev  (input cs_n, input sck, input si, input hold_n,
                output so, output so_oe_n);
  modport host (output cs_n, output sck, output si, output hold_n,
                input so_line);
endinterface : qp_link_if

/* hdl/qp_sync.sv */
/*
  Two-flop level synchroniser, W bits wide.
  Assumes each bit is a level that stays put for several destination edges.
*/
module qp_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("qp_sync: W must be at least 1");
  end

  // First stage is read only by the second
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= '0;
      o_q    <= '0;
    end else if (i_ce) begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule : qp_sync

/* hdl/qp_dev_end.sv */
/*
  Potentiometer end of the serial link: link front end on the serial clock,
  four channels of wiper and stored setting registers on the system clock.
  Assumes the host keeps the serial clock still while select is high and
  leaves select high for a few system clocks between frames.
*/
`include "qp_consts.svh"

module qp_dev_end
  import qp_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int REGS     = 4
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_reset,
  input  wire logic                      i_ce,
  input  wire logic                      i_wp_n,
  input  wire logic [1:0]                i_addr_sel,
  qp_link_if.dev                         link,
  output logic [CHANNELS-1:0][7:0]       o_wiper,
  output logic                           o_active
);
  import qp_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Two select bits each in the instruction byte fix both counts
  if (CHANNELS != 4 || REGS != 4) begin : g_chk
    $error("qp_dev_end: CHANNELS and REGS must both be 4");
  end

  // ----------------------------------------------------------------
  // System clock domain declarations
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0][7:0]           wiper_q;
  logic [CHANNELS-1:0][REGS-1:0][7:0] stored_q;
  logic [CHANNELS-1:0][7:0]           img_wiper_q;
  logic [CHANNELS-1:0][REGS-1:0][7:0] img_stored_q;
  logic                               recall_q;
  logic                               armed_q;
  logic                               link_rst_q;
  logic                               tgl_seen_q;
  logic                               active_q;
  logic [2:0]                         clk_sync;
  logic                               cs_n_s;
  logic                               wp_n_s;
  logic                               tgl_s;
  logic                               cmd_new;

  // ----------------------------------------------------------------
  // Serial clock domain declarations
  // ----------------------------------------------------------------
  logic [4:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic        id_ok_q;
  qp_op_t      op_q;
  logic [1:0]  reg_q;
  logic [1:0]  chan_q;
  logic [7:0]  wdata_q;
  logic        cmd_tgl_q;
  logic        so_q;
  logic        so_oe_n_q;
  logic [1:0]  addr_s;
  logic [7:0]  rx_byte;
  logic [7:0]  rd_byte;
  logic        rd_mode;
  logic        frame_rst;

  // ----------------------------------------------------------------
  // Crossings into the system clock and into the serial clock
  // ----------------------------------------------------------------
  // Select, write-protect pin and command toggle, all levels
  qp_sync #(
    .W       (3)
  ) u_sync_clk (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_d     ({link.cs_n, i_wp_n, cmd_tgl_q}),
    .o_q     (clk_sync)
  );

  assign cs_n_s  = clk_sync[2];
  assign wp_n_s  = clk_sync[1];
  assign tgl_s   = clk_sync[0];
  assign cmd_new = tgl_s ^ tgl_seen_q;

  // Address straps sampled on the serial clock
  qp_sync #(
    .W       (2)
  ) u_sync_sck (
    .i_clk   (link.sck),
    .i_reset (1'b0),
    .i_ce    (1'b1),
    .i_d     (i_addr_sel),
    .o_q     (addr_s)
  );

  // ----------------------------------------------------------------
  // Arming after reset and link reset
  // ----------------------------------------------------------------
  // Nothing on the link counts until select has been seen high
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      armed_q    <= 1'b0;
      link_rst_q <= 1'b1;
    end else if (i_ce) begin
      armed_q    <= armed_q | cs_n_s;
      link_rst_q <= ~(armed_q | cs_n_s);
    end
  end

  // Power state follows select; no internal write cycle is modelled
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      active_q <= 1'b0;
    end else if (i_ce) begin
      active_q <= armed_q & ~cs_n_s;
    end
  end

  // Toggle edge bookkeeping
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tgl_seen_q <= 1'b0;
    end else if (i_ce) begin
      tgl_seen_q <= tgl_s;
    end
  end

  // ----------------------------------------------------------------
  // Channel registers
  // ----------------------------------------------------------------
  // Reset stands for power-up; recall runs in the cycle after release
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      recall_q <= 1'b1;
    end else if (i_ce) begin
      recall_q <= 1'b0;
    end
  end

  // Stored settings; command fields are stable once the toggle lands
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stored_q <= {(CHANNELS*REGS){`QP_STORED_RESET}};
    end else if (i_ce && cmd_new && op_q == QP_OP_WR_STORED && wp_n_s) begin
      stored_q[chan_q][reg_q] <= wdata_q;
    end
  end

  // Wiper registers, one per channel, each picking one of 256 taps
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wiper_q <= '0;
    end else if (i_ce) begin
      if (recall_q) begin
        for (int c = 0; c < CHANNELS; c++) begin
          wiper_q[c] <= stored_q[c][0];
        end
      end else if (cmd_new) begin
        unique case (op_q)
          QP_OP_WR_WIPER: wiper_q[chan_q] <= wdata_q;
          QP_OP_XFR:      wiper_q[chan_q] <= stored_q[chan_q][reg_q];
          default:        ;
        endcase
      end
    end
  end

  assign o_wiper  = wiper_q;
  assign o_active = active_q;

  // Read image, frozen while select is low so the link sees stable words
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      img_wiper_q  <= '0;
      img_stored_q <= '0;
    end else if (i_ce && cs_n_s) begin
      img_wiper_q  <= wiper_q;
      img_stored_q <= stored_q;
    end
  end

  // ----------------------------------------------------------------
  // Serial input side
  // ----------------------------------------------------------------
  // Select high or a pending link reset clears the frame at once
  assign frame_rst = link.cs_n | link_rst_q;
  assign rx_byte   = {shift_q[6:0], link.si};

  // Bit counter and shifter; pause simply withholds the edge
  always_ff @(posedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 8'h00;
    end else if (link.hold_n) begin
      shift_q <= rx_byte;
      if (bit_cnt_q != `QP_FRAME_END) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // Identity check on the first byte
  always_ff @(posedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      id_ok_q <= 1'b0;
    end else if (link.hold_n && bit_cnt_q == `QP_ID_LAST) begin
      id_ok_q <= (rx_byte == qp_id_byte(addr_s));
    end
  end

  // Command fields survive select rising so the system side can use them
  always_ff @(posedge link.sck or posedge link_rst_q) begin
    if (link_rst_q) begin
      op_q      <= QP_OP_RD_WIPER;
      reg_q     <= 2'b00;
      chan_q    <= 2'b00;
      wdata_q   <= 8'h00;
      cmd_tgl_q <= 1'b0;
    end else if (!link.cs_n && link.hold_n && id_ok_q) begin
      if (bit_cnt_q == `QP_INS_LAST) begin
        op_q   <= qp_op_t'(rx_byte[`QP_INS_OP_MSB:`QP_INS_OP_LSB]);
        reg_q  <= rx_byte[`QP_INS_REG_MSB:`QP_INS_REG_LSB];
        chan_q <= rx_byte[`QP_INS_CH_MSB:`QP_INS_CH_LSB];
        // Transfer ends with the instruction byte
        if (rx_byte[`QP_INS_OP_MSB:`QP_INS_OP_LSB] == QP_OP_XFR) begin
          cmd_tgl_q <= ~cmd_tgl_q;
        end
      end else if (bit_cnt_q == `QP_DATA_LAST &&
                   (op_q == QP_OP_WR_WIPER || op_q == QP_OP_WR_STORED)) begin
        wdata_q   <= rx_byte;
        cmd_tgl_q <= ~cmd_tgl_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output side
  // ----------------------------------------------------------------
  // Image words are quasi-static while select is low
  always_comb begin
    rd_byte = (op_q == QP_OP_RD_WIPER) ? img_wiper_q[chan_q]
                                       : img_stored_q[chan_q][reg_q];
  end

  assign rd_mode = id_ok_q &&
                   (op_q == QP_OP_RD_WIPER || op_q == QP_OP_RD_STORED) &&
                   bit_cnt_q >= `QP_DATA_FIRST && bit_cnt_q <= `QP_DATA_LAST;

  // Data leaves on the falling edge, most significant bit first
  always_ff @(negedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      so_q      <= 1'b1;
      so_oe_n_q <= 1'b1;
    end else if (link.hold_n) begin
      if (rd_mode) begin
        so_oe_n_q <= 1'b0;
        so_q      <= rd_byte[~bit_cnt_q[2:0]];
      end else begin
        so_oe_n_q <= 1'b1;
      end
    end
  end

  assign link.so      = so_q;
  assign link.so_oe_n = so_oe_n_q;

endmodule : qp_dev_end

/* hdl/qp_host_end.sv */
/*
  Host end of the serial link: builds one frame per start request, makes
  the serial clock by dividing its own clock and collects read data.
  Assumes i_start is offered only while o_busy is low.
*/
`include "qp_consts.svh"

module qp_host_end
  import qp_pkg::*;
#(
  parameter int SCK_HALF = `QP_SCK_HALF_DEF
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_ce,
  input  wire logic       i_start,
  input  qp_pkg::qp_op_t  i_op,
  input  wire logic [1:0] i_reg,
  input  wire logic [1:0] i_chan,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_pause,
  qp_link_if.host         link,
  output logic            o_busy,
  output logic            o_done,
  output logic [7:0]      o_rdata
);
  import qp_pkg::*;

  // Synchronised data needs two cycles inside the low half
  if (SCK_HALF < 3 || SCK_HALF > 255) begin : g_chk
    $error("qp_host_end: SCK_HALF must be 3..255");
  end

  localparam logic [7:0] HALF_LAST = 8'(SCK_HALF - 1);

  qp_state_t   state_q;
  logic [7:0]  div_q;
  logic [4:0]  bits_q;
  logic [4:0]  nbits_q;
  logic [23:0] tx_q;
  logic [7:0]  rx_q;
  logic        sck_q;
  logic        cs_n_q;
  logic        hold_n_q;
  logic        busy_q;
  logic        done_q;
  logic        so_s;
  logic        tick;

  // Returned data from the far clock domain
  qp_sync #(
    .W       (1)
  ) u_sync_so (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_d     (link.so_line),
    .o_q     (so_s)
  );

  assign tick = (div_q == HALF_LAST);

  // Frame sequencer; select rests high from reset on
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q  <= QP_ST_IDLE;
      div_q    <= 8'h00;
      bits_q   <= 5'h00;
      nbits_q  <= `QP_LONG_BITS;
      tx_q     <= 24'h000000;
      rx_q     <= 8'h00;
      sck_q    <= 1'b0;
      cs_n_q   <= 1'b1;
      hold_n_q <= 1'b1;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
    end else if (i_ce) begin
      done_q <= 1'b0;
      div_q  <= tick ? 8'h00 : div_q + 8'h01;
      unique case (state_q)
        QP_ST_IDLE: begin
          div_q <= 8'h00;
          if (i_start) begin
            tx_q    <= {qp_id_byte(i_addr), i_op, i_reg, i_chan, i_wdata};
            nbits_q <= (i_op == QP_OP_XFR) ? `QP_SHORT_BITS : `QP_LONG_BITS;
            bits_q  <= 5'h00;
            cs_n_q  <= 1'b0;
            busy_q  <= 1'b1;
            state_q <= QP_ST_LEAD;
          end
        end
        QP_ST_LEAD: begin
          if (tick) begin
            state_q <= QP_ST_SHIFT;
          end
        end
        QP_ST_SHIFT: begin
          if (tick && !sck_q) begin
            // Pause is taken or released only with the clock low
            if (i_pause) begin
              hold_n_q <= 1'b0;
            end else if (!hold_n_q) begin
              hold_n_q <= 1'b1;
            end else begin
              sck_q <= 1'b1;
              rx_q  <= {rx_q[6:0], so_s};
            end
          end else if (tick) begin
            sck_q  <= 1'b0;
            tx_q   <= {tx_q[22:0], 1'b0};
            bits_q <= bits_q + 5'h01;
            if (bits_q + 5'h01 == nbits_q) begin
              state_q <= QP_ST_TAIL;
            end
          end
        end
        QP_ST_TAIL: begin
          // Hold select high a while so the far side can apply the command
          if (!cs_n_q && tick) begin
            cs_n_q <= 1'b1;
            div_q  <= 8'h00;
          end else if (cs_n_q) begin
            // Free count here; with SCK_HALF below 17 the tick wrap would never reach the gap
            div_q <= div_q + 8'h01;
            if (div_q == `QP_CS_GAP_CYC) begin
              busy_q  <= 1'b0;
              done_q  <= 1'b1;
              state_q <= QP_ST_IDLE;
            end
          end
        end
        default: state_q <= QP_ST_IDLE;
      endcase
    end
  end

  assign link.cs_n   = cs_n_q;
  assign link.sck    = sck_q;
  assign link.si     = tx_q[23];
  assign link.hold_n = hold_n_q;
  assign o_busy      = busy_q;
  assign o_done      = done_q;
  assign o_rdata     = rx_q;

endmodule : qp_host_end

/* sim/qp_link_checker.sv */
/*
  Checker of the serial link between the host end and the device end.
  Assumes every link signal moves only on rising i_clk edges or, for the
  device's data output, on the serial clock that the host makes from i_clk.
*/
module qp_link_checker (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic hold_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Rising serial clock edges within the current frame
  // ----------------------------------------------------------------
  logic [5:0] rise_cnt_q;

  // Cleared while deselected, so a frame always counts from zero
  always_ff @(posedge i_clk) begin
    if (i_reset || cs_n) begin
      rise_cnt_q <= 6'h00;
    end else if ($rose(sck)) begin
      rise_cnt_q <= rise_cnt_q + 6'h01;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // ----------------------------------------------------------------
  // Link properties
  // ----------------------------------------------------------------
  AST_OE_DESELECT: assert property (cs_n |-> so_oe_n)
    else $error("data output driven while deselected");
  AST_SO_ON_FALL: assert property ($changed(so) && !so_oe_n |-> $fell(sck))
    else $error("data output moved off a falling clock");
  AST_SI_SETTLED: assert property ($rose(sck) |-> $stable(si))
    else $error("serial input moved at a rising clock");
  AST_SCK_STILL: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  AST_HOLD_SCK_LOW: assert property ($changed(hold_n) |-> !sck && !$past(sck))
    else $error("pause moved while serial clock high");
  AST_HOLD_KEEPS: assert property (!hold_n ##1 !hold_n |-> $stable(so) && $stable(so_oe_n))
    else $error("data output moved during a pause");
  AST_FRAME_BITS: assert property ($rose(cs_n) |-> rise_cnt_q inside {6'h10, 6'h18})
    else $error("frame length is neither 16 nor 24 bits");
  AST_READ_START: assert property ($fell(so_oe_n) |-> $fell(sck) && rise_cnt_q == 6'h10)
    else $error("read data not started after the instruction byte");
  AST_READ_END: assert property ($rose(so_oe_n) |-> cs_n || rise_cnt_q == 6'h18)
    else $error("read data released early");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*5])
    else $error("select high for under 5 cycles");

  // Main traffic kinds seen at least once
  COV_READ: cover property ($fell(so_oe_n));
  COV_LONG: cover property ($rose(cs_n) && rise_cnt_q == 6'h18);
  COV_PAUSE: cover property ($fell(hold_n));
endmodule : qp_link_checker

/* sim/qp_tb_top.sv */
/*
  Testbench of the quad potentiometer serial port: host end and device end
  joined by one link, and a bit-banged link into a second device end.
  Assumes qp_consts.svh on the include path and the design files compiled.
*/
`include "qp_consts.svh"

module qp_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import qp_pkg::*;

  logic            i_clk   = 1'b0;
  logic            i_reset = 1'b1;
  logic            start, pause, wp_n, busy, done, active;
  qp_op_t          op;
  logic [1:0]      rsel, chan, addr, straps;
  logic [7:0]      wdata, rdata;
  logic [3:0][7:0] wiper, wiper_bb;
  logic [7:0]      tv [4] = '{8'h00, 8'hFF, 8'h01, 8'hFE};
  int              failures = 0;
  int              compares = 0;
  int              cyc = 0;

  // 20 MHz system clock
  always #25 i_clk = ~i_clk;

  qp_link_if qp_link_if_i ();
  qp_link_if qp_link_if_bb ();
  qp_host_end qp_host_end_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1), .i_start(start),
    .i_op(op), .i_reg(rsel), .i_chan(chan), .i_addr(addr), .i_wdata(wdata), .i_pause(pause),
    .link(qp_link_if_i.host), .o_busy(busy), .o_done(done), .o_rdata(rdata));
  qp_dev_end qp_dev_end_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1), .i_wp_n(wp_n),
    .i_addr_sel(straps), .link(qp_link_if_i.dev), .o_wiper(wiper), .o_active(active));
  // Second device end, fed by hand so that host faults can be made on purpose
  qp_dev_end qp_dev_end_bb_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1), .i_wp_n(1'b1),
    .i_addr_sel(2'b00), .link(qp_link_if_bb.dev), .o_wiper(wiper_bb), .o_active());
  qp_link_checker qp_link_checker_i (.i_clk(i_clk), .i_reset(i_reset),
    .cs_n(qp_link_if_i.cs_n), .sck(qp_link_if_i.sck), .si(qp_link_if_i.si),
    .so(qp_link_if_i.so), .so_oe_n(qp_link_if_i.so_oe_n), .hold_n(qp_link_if_i.hold_n));

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_bit

  // Cycle ceiling well above the roughly 8200 cycles the tests need
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures = failures + 1;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks, entered just after a rising edge
  // ----------------------------------------------------------------
  // One host frame; p nonzero pauses it at cycle p for 40 cycles
  task automatic xfer(input qp_op_t o, input logic [1:0] r, input logic [1:0] c,
                      input logic [1:0] a, input logic [7:0] d, input int p);
    int n;
    n = 0;
    op <= o;
    rsel <= r;
    chan <= c;
    addr <= a;
    wdata <= d;
    start <= 1'b1;
    @(posedge i_clk);
    start <= 1'b0;
    do begin
      @(posedge i_clk);
      n++;
      if (n == p) pause <= 1'b1;
      if (n == p + 40) pause <= 1'b0;
      // Done is a one-cycle pulse, so look mid-cycle
      @(negedge i_clk);
      if (n == 20) chk_bit(active, 1'b1);
      if (n == 20) chk_bit(busy, 1'b1);
    end while (done !== 1'b1 && n < 2000);
    chk_bit(done, 1'b1);
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    chk_bit(active, 1'b0);
    chk_bit(busy, 1'b0);
    @(posedge i_clk);
  endtask : xfer

  // Hand-made frame of nb bits, MSB first, on a free 15 ns serial clock;
  // select is not raised beforehand
  task automatic bb(input logic [23:0] v, input int nb);
    int k;
    qp_link_if_bb.cs_n <= 1'b0;
    #4;
    for (k = 0; k < nb; k++) begin
      qp_link_if_bb.si <= v[23-k];
      #7.5 qp_link_if_bb.sck <= 1'b1;
      #7.5 qp_link_if_bb.sck <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    qp_link_if_bb.cs_n <= 1'b1;
    repeat (16) @(posedge i_clk);
  endtask : bb

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin : main
    int a;
    start = 1'b0;
    pause = 1'b0;
    wp_n = 1'b1;
    op = QP_OP_RD_WIPER;
    {rsel, chan, addr, straps, wdata} = 16'h0000;
    {qp_link_if_bb.cs_n, qp_link_if_bb.sck, qp_link_if_bb.si} = 3'h0;
    qp_link_if_bb.hold_n = 1'b1;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (a = 0; a < 4; a++) chk_byte(wiper[a], `QP_STORED_RESET);
    $display("Test power_up done");
    // Select low since reset: frame must be ignored
    bb({`QP_DEV_TYPE, 4'h0, QP_OP_WR_WIPER, 4'h1, 8'h5A}, 24);
    chk_byte(wiper_bb[1], `QP_STORED_RESET);
    bb({`QP_DEV_TYPE, 4'h0, QP_OP_WR_WIPER, 4'h1, 8'h33}, 20);
    bb({4'h3, 4'h0, QP_OP_WR_WIPER, 4'h1, 8'h33}, 24);
    bb({`QP_DEV_TYPE, 4'h4, QP_OP_WR_WIPER, 4'h1, 8'h33}, 24);
    chk_byte(wiper_bb[1], `QP_STORED_RESET);
    bb({`QP_DEV_TYPE, 4'h0, QP_OP_WR_WIPER, 4'h1, 8'h44}, 24);
    chk_byte(wiper_bb[1], 8'h44);
    $display("Test raw_link done");
    // End taps and their neighbours, one of the four values on each channel
    for (a = 0; a < 4; a++) begin
      xfer(QP_OP_WR_WIPER, 2'h0, a[1:0], 2'h0, tv[a], 0);
      chk_byte(wiper[a], tv[a]);
      xfer(QP_OP_RD_WIPER, 2'h0, a[1:0], 2'h0, 8'h00, 0);
      chk_byte(rdata, tv[a]);
    end
    $display("Test wiper done");
    for (a = 0; a < 4; a++) begin
      xfer(QP_OP_WR_STORED, a[1:0], 2'h2, 2'h0, tv[a] ^ 8'h5A, 0);
      xfer(QP_OP_RD_STORED, a[1:0], 2'h2, 2'h0, 8'h00, 0);
      chk_byte(rdata, tv[a] ^ 8'h5A);
      xfer(QP_OP_XFR, a[1:0], 2'h2, 2'h0, 8'h00, 0);
      chk_byte(wiper[2], tv[a] ^ 8'h5A);
    end
    $display("Test stored done");
    wp_n <= 1'b0;
    xfer(QP_OP_WR_STORED, 2'h1, 2'h2, 2'h0, 8'hC3, 0);
    xfer(QP_OP_RD_STORED, 2'h1, 2'h2, 2'h0, 8'h00, 0);
    chk_byte(rdata, tv[1] ^ 8'h5A);
    wp_n <= 1'b1;
    $display("Test protect done");
    for (a = 0; a < 4; a++) begin
      straps <= a[1:0];
      repeat (4) @(posedge i_clk);
      xfer(QP_OP_WR_WIPER, 2'h0, 2'h3, a[1:0], 8'h20 + a[7:0], 0);
      xfer(QP_OP_WR_WIPER, 2'h0, 2'h3, a[1:0] ^ 2'h1, 8'hEE, 0);
      chk_byte(wiper[3], 8'h20 + a[7:0]);
      xfer(QP_OP_RD_WIPER, 2'h0, 2'h3, a[1:0] ^ 2'h2, 8'h00, 0);
      chk_byte(rdata, 8'hFF);
    end
    $display("Test address done");
    xfer(QP_OP_RD_STORED, 2'h3, 2'h2, 2'h3, 8'h00, 60);
    chk_byte(rdata, tv[3] ^ 8'h5A);
    xfer(QP_OP_WR_WIPER, 2'h0, 2'h0, 2'h3, 8'h77, 50);
    chk_byte(wiper[0], 8'h77);
    $display("Test pause done");
    close_out();
  end
endmodule : qp_tb_top
